// [bench/spi_master_model.sv]
// Mode 0 serial master driving the link at one eighth of clock.
// Assumes the caller ends each frame with stop before the next start.
module spi_master_model (
   input wire logic clock,
   input wire logic so,
   input wire logic so_oe,
   output logic sclk = 1'b0,
   output logic cs_n = 1'b1,
   output logic si = 1'b0,
   output logic hold_n = 1'b1,
   output logic oe_seen = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   // ------------------------------------------------------------
   // Frame primitives
   // ------------------------------------------------------------
   logic seen_clr = 1'b0;
   // One process owns the flag; frame start only asks for a clear
   always @(posedge clock) begin
      if (seen_clr) oe_seen <= 1'b0;
      else if (so_oe) oe_seen <= 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   // One command per select; the clock idles low between frames
   task automatic start();
      tick(1);
      cs_n <= 1'b0;
      seen_clr <= 1'b1;
      tick(1);
      seen_clr <= 1'b0;
      tick(3);
   endtask
   task automatic stop();
      tick(2);
      cs_n <= 1'b1;
      si <= ~si;  // Released line shows no stale bit
      tick(6);
   endtask
   // Pause moves only with the clock low; clocks meanwhile are noise
   task automatic pause();
      tick(1);  // Let the falling clock edge settle before pausing
      hold_n <= 1'b0;
      tick(4);
      repeat (2) begin
         sclk <= 1'b1;
         tick(4);
         sclk <= 1'b0;
         tick(4);
      end
      hold_n <= 1'b1;
      tick(4);
   endtask
   // Bits leave MSB first; so is read late in the high phase
   task automatic xfer(input logic [7:0] tx, input int nbits, input int pause_at,
                       output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - nbits; i--) begin
         if (i == pause_at) pause();
         si <= tx[i];
         tick(4);
         sclk <= 1'b1;
         tick(3);
         @(negedge clock);
         rx[i] = so;
         @(posedge clock);
         sclk <= 1'b0;
      end
   endtask
endmodule

// [bench/spi_nvram_read_write_hold_assertions.sv]
// Port checker for the serial nonvolatile RAM access block.
// Assumes a single clock domain and the asynchronous active-high reset.
module spi_nvram_read_write_hold_checker #(
   parameter int unsigned POWER_UP_CYCLES = 25000
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic si,
   input wire logic hold_n,
   input wire logic block_guard_hi,
   input wire logic block_guard_lo,
   input wire logic so,
   input wire logic so_oe,
   input wire logic write_latch_flag,
   input wire logic power_up_done
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // Cycle count since reset, saturating so it never wraps
   // ------------------------------------------------------------
   logic [15:0] cyc;
   logic [15:0] next_cyc;
   always_comb next_cyc = (cyc == 16'hFFFF) ? cyc : cyc + 16'h0001;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) cyc <= 16'h0000;
      else cyc <= next_cyc;
   end
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   AST_PU_STAY: assert property (power_up_done |=> power_up_done)
      else $error("ready flag dropped");
   AST_PU_TIME: assert property ($rose(power_up_done) |->
      cyc >= POWER_UP_CYCLES - 1 && cyc <= POWER_UP_CYCLES + 2)
      else $error("ready flag at wrong cycle");
   AST_IDLE_BEFORE_PU: assert property (!power_up_done |-> !so_oe && !write_latch_flag)
      else $error("activity before ready");
   // Two synchroniser stages put the select pin two samples behind the enable
   AST_OE_SELECT: assert property (so_oe |-> !$past(cs_n, 2))
      else $error("output on while deselected");
   AST_OE_DESELECT: assert property ($rose(cs_n) |-> ##[1:6] !so_oe)
      else $error("output not off after deselect");
   // Pause adds one register after the synchroniser, so three samples of lag
   AST_OE_PAUSE: assert property (so_oe |-> $past(hold_n, 3))
      else $error("output on while paused");
   AST_SO_ON_FALL: assert property (so_oe && $changed(so) |-> !$past(sclk, 2))
      else $error("output moved outside clock low");
   AST_OE_RISE: assert property ($rose(so_oe) |-> !sclk && !$past(sclk, 2))
      else $error("output enabled outside clock low");
   AST_LATCH_IN_FRAME: assert property ($changed(write_latch_flag) |-> !$past(cs_n, 6))
      else $error("latch moved outside a frame");
   AST_LATCH_SET: assert property ($rose(write_latch_flag) |-> !cs_n && hold_n)
      else $error("latch set while idle");
   cover property ($rose(so_oe));
   cover property ($fell(write_latch_flag));
   cover property ($fell(hold_n) && !sclk);
endmodule

bind spi_nvram_read_write_hold spi_nvram_read_write_hold_checker #(
   .POWER_UP_CYCLES(POWER_UP_CYCLES)
) u_checker (
   .clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n), .si(si), .hold_n(hold_n),
   .block_guard_hi(block_guard_hi), .block_guard_lo(block_guard_lo), .so(so),
   .so_oe(so_oe), .write_latch_flag(write_latch_flag), .power_up_done(power_up_done)
);

// [bench/spi_nvram_read_write_hold_bench.sv]
// Self-checking bench for the serial nonvolatile RAM access block.
// Assumes the master model in spi_master_model.sv and a 25 MHz clock.
module spi_nvram_read_write_hold_bench import nvram_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned PU = 200;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic block_guard_hi = 1'b0;
   logic block_guard_lo = 1'b0;
   logic sclk, cs_n, si, hold_n, so, so_oe, write_latch_flag, power_up_done, oe_seen;
   logic [7:0] rx;
   logic [7:0] mem [0:2047];
   int fail_count = 0;
   int n_tests = 0;
   always #20 clock = ~clock;
   spi_nvram_read_write_hold #(.POWER_UP_CYCLES(PU)) u_spi_nvram_read_write_hold (
      .clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n), .si(si), .hold_n(hold_n),
      .block_guard_hi(block_guard_hi), .block_guard_lo(block_guard_lo), .so(so),
      .so_oe(so_oe), .write_latch_flag(write_latch_flag), .power_up_done(power_up_done));
   spi_master_model u_spi_master_model (.clock(clock), .so(so), .so_oe(so_oe),
      .sclk(sclk), .cs_n(cs_n), .si(si), .hold_n(hold_n), .oe_seen(oe_seen));
   // ------------------------------------------------------------
   // Compare, report and frame helpers
   // ------------------------------------------------------------
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_flag(input string what, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask
   function automatic logic guarded(input logic [10:0] a);
      return block_guard_hi ? (block_guard_lo || a >= 11'h400) : (block_guard_lo && a >= 11'h600);
   endfunction
   task automatic cmd(input logic [7:0] op);
      u_spi_master_model.start();
      u_spi_master_model.xfer(op, 8, -1, rx);
      u_spi_master_model.stop();
   endtask
   task automatic hdr(input logic [7:0] op, input logic [15:0] a);
      u_spi_master_model.start();
      u_spi_master_model.xfer(op, 8, -1, rx);
      u_spi_master_model.xfer(a[15:8], 8, -1, rx);
      u_spi_master_model.xfer(a[7:0], 8, -1, rx);
   endtask
   // Mirror only takes bytes that complete all eight clocks
   task automatic wr(input logic [15:0] a, input logic [7:0] d [$], input logic latch,
                     input int part);
      logic [10:0] p;
      p = a[10:0];
      if (latch) cmd(SET_WRITE_LATCH_CMD);
      check_flag("latch", latch, write_latch_flag);
      hdr(WRITE_MEM_CMD, a);
      foreach (d[i]) begin
         u_spi_master_model.xfer(d[i], 8, -1, rx);
         if (latch && !guarded(p)) mem[p] = d[i];
         p++;
      end
      if (part > 0) u_spi_master_model.xfer(8'hFF, part, -1, rx);
      u_spi_master_model.stop();
      check_flag("latch", 1'b0, write_latch_flag);
   endtask
   // Toggling si during data shows that input is ignored
   task automatic rd(input logic [15:0] a, input int n, input int pause_at);
      logic [10:0] p;
      p = a[10:0];
      hdr(READ_MEM_CMD, a);
      for (int i = 0; i < n; i++) begin
         u_spi_master_model.xfer(8'hA5 ^ 8'(i), 8, (i == 1) ? pause_at : -1, rx);
         check_byte("read", mem[p], rx);
         p++;
      end
      u_spi_master_model.stop();
      check_flag("oe off", 1'b0, so_oe);
      check_flag("oe seen", 1'b1, oe_seen);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_power_up();
      int n;
      cmd(SET_WRITE_LATCH_CMD);
      check_flag("latch", 1'b0, write_latch_flag);
      check_flag("ready", 1'b0, power_up_done);
      n = 0;
      while (power_up_done !== 1'b1 && n < PU) begin
         @(posedge clock);
         n++;
      end
      if (n >= PU) begin
         fail_count++;
         test_done();
      end
      repeat (4) @(posedge clock);
   endtask
   task automatic t_write_wrap();
      wr(16'h0002, {8'h55}, 1'b1, 0);
      wr(16'hF7FE, {8'h11, 8'h22, 8'h33, 8'h44}, 1'b1, 4);
      rd(16'hA7FE, 5, -1);
      wr(16'h0000, {8'h99}, 1'b0, 0);
      rd(16'h0000, 1, -1);
   endtask
   task automatic t_codes();
      logic [7:0] ign [3] = '{STATUS_READ_CMD, STATUS_WRITE_CMD, 8'hFF};
      cmd(SET_WRITE_LATCH_CMD);
      check_flag("latch", 1'b1, write_latch_flag);
      cmd(CLEAR_WRITE_LATCH_CMD);
      check_flag("latch", 1'b0, write_latch_flag);
      foreach (ign[i]) begin
         u_spi_master_model.start();
         u_spi_master_model.xfer(ign[i], 8, -1, rx);
         u_spi_master_model.xfer(8'h0F, 8, -1, rx);
         u_spi_master_model.stop();
         check_flag("oe seen", 1'b0, oe_seen);
      end
   endtask
   task automatic t_guard();
      for (int g = 0; g < 4; g++) begin
         @(posedge clock);
         {block_guard_hi, block_guard_lo} <= 2'(g);
         @(posedge clock);
         wr(16'h03FF, {8'h30 + 8'(g), 8'h40 + 8'(g)}, 1'b1, 0);
         wr(16'h05FF, {8'h60 + 8'(g), 8'h70 + 8'(g)}, 1'b1, 0);
         rd(16'h03FF, 2, -1);
         rd(16'h05FF, 2, -1);
      end
   endtask
   // ------------------------------------------------------------
   // Main sequence and hang guard
   // ------------------------------------------------------------
   initial begin
      repeat (100000) @(posedge clock);
      fail_count++;
      test_done();
   end
   initial begin
      repeat (20) @(posedge clock);
      check_flag("latch", 1'b0, write_latch_flag);
      rst <= 1'b0;
      t_power_up();
      t_write_wrap();
      t_codes();
      t_guard();
      rd(16'h07FE, 3, 3);
      test_done();
   end
endmodule

// [src/nvram_pkg.sv]
// Shared constants for the serial nonvolatile RAM access block.
// Assumes a 25 MHz system clock that oversamples the serial link.
package nvram_pkg;

   // -------------------------------------------------------------
   // Array geometry
   // -------------------------------------------------------------
   localparam int unsigned ADDR_W = 11;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned DEPTH = 2048;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 11'h000;
   localparam logic [ADDR_W-1:0] ADDR_ONE = 11'h001;
   localparam logic [ADDR_W-1:0] GUARD_QUARTER_BASE = 11'h600;
   localparam logic [ADDR_W-1:0] GUARD_HALF_BASE = 11'h400;

   // -------------------------------------------------------------
   // Command bytes
   // -------------------------------------------------------------
   localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
   localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
   localparam logic [7:0] STATUS_READ_CMD = 8'h05;
   localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
   localparam logic [7:0] READ_MEM_CMD = 8'h03;
   localparam logic [7:0] WRITE_MEM_CMD = 8'h02;

   // -------------------------------------------------------------
   // Serial framing
   // -------------------------------------------------------------
   localparam int unsigned SHIFT_W = 16;
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BIT_STEP = 3'h1;
   localparam int unsigned BUF_DEPTH = 2;
   localparam logic [1:0] BUF_FULL = 2'h2;
   localparam logic [1:0] BUF_EMPTY = 2'h0;
   localparam logic [1:0] BUF_ONE = 2'h1;

   // -------------------------------------------------------------
   // Power-up wait
   // -------------------------------------------------------------
   localparam int unsigned CLOCK_HZ = 25_000_000;
   localparam int unsigned POWER_UP_WAIT_MS = 1;
   localparam int unsigned POWER_UP_WAIT_CYCLES = CLOCK_HZ / 1000 * POWER_UP_WAIT_MS;
   localparam int unsigned PU_W = 15;
   localparam logic [PU_W-1:0] PU_ZERO = 15'h0000;
   localparam logic [PU_W-1:0] PU_STEP = 15'h0001;

   typedef enum logic [4:0] {
      st_cmd = 5'h01,
      st_addr = 5'h02,
      st_wdata = 5'h04,
      st_rdata = 5'h08,
      st_skip = 5'h10
   } phase_t;

endpackage

// [src/spi_nvram_read_write_hold.sv]
// Memory-access core of a serial nonvolatile RAM behind an SPI slave port.
// Assumes the link pins are asynchronous to clock and that the serial clock
// runs at most one eighth of clock; status register logic lives elsewhere.
//
// Function
// - Upper five address bits are ignored; lower eleven give the start location.
// - Every byte after the address is data, stored consecutively without page limit.
// - Address counter steps after each byte and wraps from top to zero.
// - A write byte is stored right after its eighth clock, no busy time.
// - Write data bytes arrive most significant bit first.
// - Select rising ends a write; nothing more is stored.
// - After read command and address, serial input is ignored until deselect.
// - One bit out per clock, eight per byte, MSB first, bytes stream on.
// - Select rising ends a read and stops the output.
// - Pause low while serial clock low freezes the operation, keeping state.
// - Pause high while serial clock low resumes the frozen operation.
// - Command bytes use the six fixed codes for latch, status and memory.
// - Input sampled on rising clock, output driven on falling clock, MSB first.
// - Finishing any memory write clears the write latch; a new set command is needed.
// - Bytes aimed at a guarded range, chosen by the two guard bits, are dropped.
module spi_nvram_read_write_hold
   import nvram_pkg::*;
#(
   parameter int unsigned POWER_UP_CYCLES = POWER_UP_WAIT_CYCLES
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic si,
   input wire logic hold_n,
   input wire logic block_guard_hi,
   input wire logic block_guard_lo,
   output logic so,
   output logic so_oe,
   output logic write_latch_flag,
   output logic power_up_done
);

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   function automatic logic guarded(input logic [ADDR_W-1:0] a,
                                    input logic hi,
                                    input logic lo);
      logic g;
      g = 1'b0;
      case ({hi, lo})
         2'h1: g = (a >= GUARD_QUARTER_BASE);
         2'h2: g = (a >= GUARD_HALF_BASE);
         2'h3: g = 1'b1;
         default: g = 1'b0;
      endcase
      return g;
   endfunction

   // Top location plus one wraps to zero by the width itself
   function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a);
      return a + ADDR_ONE;
   endfunction

   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   logic [3:0] pin_meta;
   logic [3:0] pin_sync;
   logic sclk_s;
   logic cs_s;
   logic si_s;
   logic hold_s;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pin_meta <= 4'hF;
         pin_sync <= 4'hF;
      end else begin
         pin_meta <= {hold_n, si, cs_n, sclk};
         pin_sync <= pin_meta;
      end
   end

   assign sclk_s = pin_sync[0];
   assign cs_s = pin_sync[1];
   assign si_s = pin_sync[2];
   assign hold_s = pin_sync[3];

   // -------------------------------------------------------------
   // Power-up wait, edge finding and pause
   // -------------------------------------------------------------
   logic [PU_W-1:0] pu_cnt;
   logic [PU_W-1:0] next_pu_cnt;
   logic pu_done;
   logic next_pu_done;
   logic sclk_q;
   logic cs_q;
   logic paused;
   logic next_paused;
   logic sel;
   logic rise;
   logic fall;
   logic cs_rise;

   always_comb begin
      next_pu_cnt = pu_cnt;
      next_pu_done = pu_done;
      if (!pu_done) begin
         next_pu_cnt = pu_cnt + PU_STEP;
         next_pu_done = (pu_cnt == PU_W'(POWER_UP_CYCLES - 1));
      end
      next_paused = paused;
      if (!sclk_s) begin
         next_paused = !hold_s;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pu_cnt <= PU_ZERO;
         pu_done <= 1'b0;
         sclk_q <= 1'b1;
         cs_q <= 1'b1;
         paused <= 1'b0;
      end else begin
         pu_cnt <= next_pu_cnt;
         pu_done <= next_pu_done;
         sclk_q <= sclk_s;
         cs_q <= cs_s;
         paused <= next_paused;
      end
   end

   // Selects before the wait has run out are not seen at all
   assign sel = !cs_s && pu_done;
   assign rise = sel && !paused && sclk_s && !sclk_q;
   assign fall = sel && !paused && !sclk_s && sclk_q;
   assign cs_rise = cs_s && !cs_q;

   // -------------------------------------------------------------
   // Command, address and write path
   // -------------------------------------------------------------
   logic [DATA_W-1:0] mem [DEPTH];
   phase_t state;
   phase_t next_state;
   logic [2:0] bit_cnt;
   logic [2:0] next_bit_cnt;
   logic second;
   logic next_second;
   logic [SHIFT_W-1:0] in_sr;
   logic [SHIFT_W-1:0] next_in_sr;
   logic [ADDR_W-1:0] addr;
   logic [ADDR_W-1:0] next_addr;
   logic wr_op;
   logic next_wr_op;
   logic latch;
   logic next_latch;
   logic mem_we;
   logic [DATA_W-1:0] mem_wd;
   logic push;
   logic buf_ready;

   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_second = second;
      next_in_sr = in_sr;
      next_addr = addr;
      next_wr_op = wr_op;
      next_latch = latch;
      mem_we = 1'b0;
      mem_wd = in_sr[DATA_W-1:0];
      push = 1'b0;
      if (cs_rise && wr_op) begin
         next_latch = 1'b0;
      end
      if (!sel) begin
         // Partial bytes die here with the shift register unused
         next_state = st_cmd;
         next_bit_cnt = BIT_FIRST;
         next_second = 1'b0;
         next_wr_op = 1'b0;
      end else if (rise && (state != st_rdata) && (state != st_skip)) begin
         next_in_sr = {in_sr[SHIFT_W-2:0], si_s};
         next_bit_cnt = bit_cnt + BIT_STEP;
         if (bit_cnt == BIT_LAST) begin
            case (state)
               st_cmd: begin
                  next_state = st_skip;
                  case (next_in_sr[DATA_W-1:0])
                     READ_MEM_CMD: next_state = st_addr;
                     WRITE_MEM_CMD: begin
                        next_state = st_addr;
                        next_wr_op = 1'b1;
                     end
                     SET_WRITE_LATCH_CMD: next_latch = 1'b1;
                     CLEAR_WRITE_LATCH_CMD: next_latch = 1'b0;
                     default: next_state = st_skip;
                  endcase
               end
               st_addr: begin
                  next_second = 1'b1;
                  if (second) begin
                     next_addr = next_in_sr[ADDR_W-1:0];
                     next_state = wr_op ? st_wdata : st_rdata;
                  end
               end
               st_wdata: begin
                  // Stored on the eighth edge itself, never deferred
                  mem_wd = next_in_sr[DATA_W-1:0];
                  mem_we = latch && !guarded(addr, block_guard_hi,
                                             block_guard_lo);
                  next_addr = step_addr(addr);
               end
               default: next_state = state;
            endcase
         end
      end else if ((state == st_rdata) && buf_ready) begin
         push = 1'b1;
         next_addr = step_addr(addr);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= st_cmd;
         bit_cnt <= BIT_FIRST;
         second <= 1'b0;
         in_sr <= '0;
         addr <= ADDR_ZERO;
         wr_op <= 1'b0;
         latch <= 1'b0;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         second <= next_second;
         in_sr <= next_in_sr;
         addr <= next_addr;
         wr_op <= next_wr_op;
         latch <= next_latch;
      end
   end

   always_ff @(posedge clock) begin
      if (mem_we) begin
         mem[addr] <= mem_wd;
      end
   end

   // -------------------------------------------------------------
   // Read prefetch buffer
   // -------------------------------------------------------------
   // Two bytes are fetched ahead so the shifter never waits on the array;
   // it fills while the shifter is busy and stalls the fetch when full.
   logic [DATA_W-1:0] buf_mem [BUF_DEPTH];
   logic [DATA_W-1:0] next_buf_mem [BUF_DEPTH];
   logic [1:0] buf_cnt;
   logic [1:0] next_buf_cnt;
   logic buf_wp;
   logic next_buf_wp;
   logic buf_rp;
   logic next_buf_rp;
   logic buf_valid;
   logic pop;

   assign buf_ready = (buf_cnt != BUF_FULL);
   assign buf_valid = (buf_cnt != BUF_EMPTY);

   always_comb begin
      next_buf_mem = buf_mem;
      next_buf_cnt = buf_cnt;
      next_buf_wp = buf_wp;
      next_buf_rp = buf_rp;
      if (!sel) begin
         next_buf_cnt = BUF_EMPTY;
         next_buf_wp = 1'b0;
         next_buf_rp = 1'b0;
      end else begin
         if (push) begin
            next_buf_mem[buf_wp] = mem[addr];
            next_buf_wp = !buf_wp;
         end
         if (pop && buf_valid) begin
            next_buf_rp = !buf_rp;
         end
         if (push && !(pop && buf_valid)) begin
            next_buf_cnt = buf_cnt + BUF_ONE;
         end else if (!push && pop && buf_valid) begin
            next_buf_cnt = buf_cnt - BUF_ONE;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         buf_mem <= '{default: '0};
         buf_cnt <= BUF_EMPTY;
         buf_wp <= 1'b0;
         buf_rp <= 1'b0;
      end else begin
         buf_mem <= next_buf_mem;
         buf_cnt <= next_buf_cnt;
         buf_wp <= next_buf_wp;
         buf_rp <= next_buf_rp;
      end
   end

   // -------------------------------------------------------------
   // Output shifter
   // -------------------------------------------------------------
   logic [DATA_W-1:0] out_sr;
   logic [DATA_W-1:0] next_out_sr;
   logic [2:0] out_bit;
   logic [2:0] next_out_bit;
   logic out_on;
   logic next_out_on;
   logic so_q;
   logic next_so_q;

   always_comb begin
      next_out_sr = out_sr;
      next_out_bit = out_bit;
      next_out_on = out_on;
      next_so_q = so_q;
      pop = 1'b0;
      if (!sel) begin
         next_out_bit = BIT_FIRST;
         next_out_on = 1'b0;
         next_so_q = 1'b0;
      end else if (fall && (state == st_rdata)) begin
         next_out_on = 1'b1;
         next_out_bit = out_bit + BIT_STEP;
         if (out_bit == BIT_FIRST) begin
            pop = 1'b1;
            next_so_q = buf_mem[buf_rp][DATA_W-1];
            next_out_sr = {buf_mem[buf_rp][DATA_W-2:0], 1'b0};
         end else begin
            next_so_q = out_sr[DATA_W-1];
            next_out_sr = {out_sr[DATA_W-2:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         out_sr <= '0;
         out_bit <= BIT_FIRST;
         out_on <= 1'b0;
         so_q <= 1'b0;
      end else begin
         out_sr <= next_out_sr;
         out_bit <= next_out_bit;
         out_on <= next_out_on;
         so_q <= next_so_q;
      end
   end

   // Pin released during a pause so the bus can be shared
   assign so = so_q;
   assign so_oe = out_on && sel && !paused;
   assign write_latch_flag = latch;
   assign power_up_done = pu_done;

endmodule
